// file: rtl/frgch_pkg.sv
// constants, packet layout, state codes and shared functions of the field read/get handler
// assumes a byte-wide command stream in and a byte-wide response stream out, one clock
//
// What this block does
// - a stored-field read command has type 0x5246 after the 0x5555 sync and reads power-up defaults from the stored bank.
// - the stored-field read may return configuration and calibration fields only.
// - if at least one stored field reads, a read response lists the ids and data of just those fields.
// - if any stored field fails, an error response is sent, possibly after a read response.
// - the read response has type 0x5246, length 1 + 4 x count, then count and id/data pairs at odd offsets.
// - a live-field get command has type 0x4746 and returns values held in the working bank.
// - the live-field get may return configuration, calibration and algorithm fields.
// - algorithm fields in one get response need not come from the same algorithm iteration.
// - if at least one live field is collected, a get response carries those ids and their data.
// - if any live field fails, an error response is sent, possibly after a get response.
// - the get response has type 0x4746, length 1 + 4 x count, last data at offset 4 x count - 1.
// - every packet ends in a 16-bit crc and every id and data word is two bytes unsigned.
package frgch_pkg;

  localparam logic [7:0]  SYNC_BYTE        = 8'h55;
  localparam logic [15:0] TYPE_STORED_READ = 16'h5246;
  localparam logic [15:0] TYPE_LIVE_GET    = 16'h4746;
  localparam logic [15:0] TYPE_ERROR       = 16'h1515;
  localparam logic [7:0]  ERR_LEN          = 8'h02;
  localparam logic [15:0] CRC_POLY         = 16'h1021;
  localparam logic [15:0] CRC_INIT         = 16'hFFFF;
  localparam int          FIELD_AW         = 8;
  localparam logic [15:0] FIELD_LIMIT      = 16'h0100;
  localparam logic [15:0] ALG_ID_BASE      = 16'h00C0;
  localparam logic [2:0]  HDR_LAST_RESP    = 3'h5;
  localparam logic [2:0]  HDR_LAST_ERR     = 3'h6;
  localparam logic [2:0]  HDR_CRC_FIRST    = 3'h2;
  localparam logic [1:0]  STEP_ID          = 2'h0;
  localparam logic [1:0]  STEP_VAL         = 2'h1;
  localparam logic [1:0]  STEP_USE         = 2'h2;
  localparam logic [7:0]  BYTE_RST         = 8'h00;
  localparam logic [15:0] WORD_RST         = 16'h0000;

  typedef enum logic [4:0] {
    ST_SYNC0  = 5'h00,
    ST_SYNC1  = 5'h01,
    ST_TYPE_H = 5'h03,
    ST_TYPE_L = 5'h02,
    ST_LEN    = 5'h06,
    ST_CNT    = 5'h07,
    ST_ID_H   = 5'h05,
    ST_ID_L   = 5'h04,
    ST_CRC_H  = 5'h0C,
    ST_CRC_L  = 5'h0D,
    ST_SCAN   = 5'h0F,
    ST_HDR    = 5'h0E,
    ST_FIELD  = 5'h0A,
    ST_TAIL   = 5'h0B,
    ST_ERR    = 5'h09
  } frgch_state_t;

  // crc-16, polynomial 0x1021, one byte msb first
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // stored reads reach config and calibration ids, live gets also algorithm ids
  function automatic logic field_ok(input logic [15:0] id, input logic live);
    return (id < FIELD_LIMIT) && (live || (id < ALG_ID_BASE));
  endfunction

  // header bytes: sync, sync, type, length, then two free payload bytes
  function automatic logic [7:0] pkt_byte(input logic [2:0] idx, input logic [15:0] ptype,
                                          input logic [7:0] len, input logic [7:0] b5,
                                          input logic [7:0] b6);
    logic [7:0] r;
    r = SYNC_BYTE;
    if (idx == 3'h2) begin
      r = ptype[15:8];
    end else if (idx == 3'h3) begin
      r = ptype[7:0];
    end else if (idx == 3'h4) begin
      r = len;
    end else if (idx == 3'h5) begin
      r = b5;
    end else if (idx == 3'h6) begin
      r = b6;
    end
    return r;
  endfunction

endpackage

// file: rtl/frgch_byte_if.sv
// byte stream with valid and ready between the handler core and its output buffer
// assumes both ends sit on ref_clk
`timescale 1ns/10ps
interface frgch_byte_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// file: rtl/frgch_ram.sv
// small synchronous memory, one write port, one read port, registered read data
// assumes write and read share ref_clk; no reset on contents
`timescale 1ns/10ps
module frgch_ram #(
  parameter int DW = 16,
  parameter int AW = 8
) (
  input  wire logic          ref_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // write then registered read
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// file: rtl/frgch_buf2.sv
// two-entry output buffer, registered head drives the response pins
// assumes same clock on both sides; ready on the fill side is low only when both slots hold
`timescale 1ns/10ps
module frgch_buf2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  frgch_byte_if.snk             in_if,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] s0_r, s0_nxt, s1_r, s1_nxt;
  logic             v0_r, v0_nxt, v1_r, v1_nxt;
  logic             pop, push;

  assign in_if.ready = ~v1_r;
  assign out_data    = s0_r;
  assign out_valid   = v0_r;

  // pop from head, shift second slot forward, then place new word
  always_comb begin
    pop    = v0_r & out_ready;
    push   = in_if.valid & ~v1_r;
    s0_nxt = s0_r;
    s1_nxt = s1_r;
    v0_nxt = v0_r;
    v1_nxt = v1_r;
    if (pop) begin
      if (v1_r) begin
        s0_nxt = s1_r;
        v1_nxt = 1'b0;
      end else begin
        v0_nxt = 1'b0;
      end
    end
    if (push) begin
      if (!v0_nxt) begin
        s0_nxt = in_if.data;
        v0_nxt = 1'b1;
      end else begin
        s1_nxt = in_if.data;
        v1_nxt = 1'b1;
      end
    end
  end

  // slot registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s0_r <= '0;
      s1_r <= '0;
      v0_r <= 1'b0;
      v1_r <= 1'b0;
    end else begin
      s0_r <= s0_nxt;
      s1_r <= s1_nxt;
      v0_r <= v0_nxt;
      v1_r <= v1_nxt;
    end
  end
endmodule

// file: rtl/frgch_top.sv
// field read/get command handler: parses framed commands, looks up fields, answers
// assumes rx bytes come from a framer on ref_clk; tx goes to a serialiser that may stall
`timescale 1ns/10ps
module frgch_top #(
  parameter int MAX_FIELDS = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic        upd_en,
  input  wire logic        upd_live,
  input  wire logic [15:0] upd_id,
  input  wire logic [15:0] upd_value
);
  localparam int IW = $clog2(MAX_FIELDS);
  localparam logic [7:0] MAX_CNT = 8'(MAX_FIELDS);

  frgch_pkg::frgch_state_t state_r, state_nxt;
  logic [7:0]  idx_r, idx_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic [7:0]  len_r, len_nxt;
  logic [7:0]  hi_r, hi_nxt;
  logic [15:0] typ_r, typ_nxt;
  logic [15:0] rx_crc_r, rx_crc_nxt;
  logic [15:0] tx_crc_r, tx_crc_nxt;
  logic [7:0]  ok_cnt_r, ok_cnt_nxt;
  logic        fail_r, fail_nxt;
  logic        err_r, err_nxt;
  logic        live_r, live_nxt;
  logic [1:0]  step_r, step_nxt;
  logic [2:0]  bsel_r, bsel_nxt;
  logic [15:0] id_r, id_nxt;
  logic        rx_ready_nxt;

  logic        take;
  logic        push;
  logic [15:0] id_q, stored_q, live_q, val;
  logic        ok_now, last_idx;
  logic [7:0]  resp_len;

  frgch_byte_if bif ();

  // id list of the command in payload order
  frgch_ram #(
    .DW (16),
    .AW (IW)
  ) u_id_ram (
    .ref_clk (ref_clk),
    .we      (take && (state_r == frgch_pkg::ST_ID_L)),
    .waddr   (idx_r[IW-1:0]),
    .wdata   ({hi_r, rx_data}),
    .raddr   (idx_r[IW-1:0]),
    .rdata   (id_q)
  );

  // power-up default bank
  frgch_ram #(
    .DW (16),
    .AW (frgch_pkg::FIELD_AW)
  ) u_stored_ram (
    .ref_clk (ref_clk),
    .we      (upd_en && !upd_live && (upd_id < frgch_pkg::FIELD_LIMIT)),
    .waddr   (upd_id[frgch_pkg::FIELD_AW-1:0]),
    .wdata   (upd_value),
    .raddr   (id_q[frgch_pkg::FIELD_AW-1:0]),
    .rdata   (stored_q)
  );

  // working bank, updated freely by the algorithm side
  frgch_ram #(
    .DW (16),
    .AW (frgch_pkg::FIELD_AW)
  ) u_live_ram (
    .ref_clk (ref_clk),
    .we      (upd_en && upd_live && (upd_id < frgch_pkg::FIELD_LIMIT)),
    .waddr   (upd_id[frgch_pkg::FIELD_AW-1:0]),
    .wdata   (upd_value),
    .raddr   (id_q[frgch_pkg::FIELD_AW-1:0]),
    .rdata   (live_q)
  );

  // response buffer, stall on tx_ready backs up into the emitter
  frgch_buf2 #(
    .WIDTH (8)
  ) u_buf (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_if     (bif),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );

  // lookup status of the current field
  assign take     = rx_valid & rx_ready;
  assign push     = bif.valid & bif.ready;
  assign val      = live_r ? live_q : stored_q;
  assign ok_now   = frgch_pkg::field_ok(id_r, live_r);
  assign last_idx = (idx_r + 8'h01) == cnt_r;
  assign resp_len = 8'h01 + {ok_cnt_r[5:0], 2'b00};

  // byte offered to the output buffer
  always_comb begin
    bif.valid = 1'b0;
    bif.data  = frgch_pkg::BYTE_RST;
    case (state_r)
      frgch_pkg::ST_HDR: begin
        bif.valid = 1'b1;
        bif.data  = frgch_pkg::pkt_byte(bsel_r, typ_r, resp_len, ok_cnt_r, 8'h00);
      end
      frgch_pkg::ST_ERR: begin
        bif.valid = 1'b1;
        bif.data  = frgch_pkg::pkt_byte(bsel_r, frgch_pkg::TYPE_ERROR, frgch_pkg::ERR_LEN,
                                        typ_r[15:8], typ_r[7:0]);
      end
      frgch_pkg::ST_FIELD: begin
        bif.valid = (step_r == frgch_pkg::STEP_USE) && ok_now;
        case (bsel_r[1:0])
          2'h0: bif.data = id_r[15:8];
          2'h1: bif.data = id_r[7:0];
          2'h2: bif.data = val[15:8];
          default: bif.data = val[7:0];
        endcase
      end
      frgch_pkg::ST_TAIL: begin
        bif.valid = 1'b1;
        bif.data  = bsel_r[0] ? tx_crc_r[7:0] : tx_crc_r[15:8];
      end
      default: begin
        bif.valid = 1'b0;
      end
    endcase
  end

  // command parse, field scan and response sequencing
  always_comb begin
    state_nxt  = state_r;
    idx_nxt    = idx_r;
    cnt_nxt    = cnt_r;
    len_nxt    = len_r;
    hi_nxt     = hi_r;
    typ_nxt    = typ_r;
    rx_crc_nxt = rx_crc_r;
    tx_crc_nxt = tx_crc_r;
    ok_cnt_nxt = ok_cnt_r;
    fail_nxt   = fail_r;
    err_nxt    = err_r;
    live_nxt   = live_r;
    step_nxt   = step_r;
    bsel_nxt   = bsel_r;
    id_nxt     = id_r;
    // gray codes carry no order, so the crc states are listed one by one
    if (take && (state_r inside {frgch_pkg::ST_TYPE_H, frgch_pkg::ST_TYPE_L, frgch_pkg::ST_LEN,
                                 frgch_pkg::ST_CNT, frgch_pkg::ST_ID_H, frgch_pkg::ST_ID_L})) begin
      rx_crc_nxt = frgch_pkg::crc16_byte(rx_crc_r, rx_data);
    end
    if (push && !((state_r == frgch_pkg::ST_HDR || state_r == frgch_pkg::ST_ERR)
                  && bsel_r < frgch_pkg::HDR_CRC_FIRST) && state_r != frgch_pkg::ST_TAIL) begin
      tx_crc_nxt = frgch_pkg::crc16_byte(tx_crc_r, bif.data);
    end
    case (state_r)
      frgch_pkg::ST_SYNC0: begin
        err_nxt = 1'b0;
        if (take && rx_data == frgch_pkg::SYNC_BYTE) begin
          state_nxt = frgch_pkg::ST_SYNC1;
        end
      end
      frgch_pkg::ST_SYNC1: begin
        if (take) begin
          state_nxt  = (rx_data == frgch_pkg::SYNC_BYTE) ? frgch_pkg::ST_TYPE_H
                                                         : frgch_pkg::ST_SYNC0;
          rx_crc_nxt = frgch_pkg::CRC_INIT;
        end
      end
      frgch_pkg::ST_TYPE_H: begin
        if (take) begin
          hi_nxt    = rx_data;
          state_nxt = frgch_pkg::ST_TYPE_L;
        end
      end
      frgch_pkg::ST_TYPE_L: begin
        if (take) begin
          typ_nxt   = {hi_r, rx_data};
          live_nxt  = ({hi_r, rx_data} == frgch_pkg::TYPE_LIVE_GET);
          state_nxt = ({hi_r, rx_data} == frgch_pkg::TYPE_STORED_READ ||
                       {hi_r, rx_data} == frgch_pkg::TYPE_LIVE_GET)
                      ? frgch_pkg::ST_LEN : frgch_pkg::ST_SYNC0;
        end
      end
      frgch_pkg::ST_LEN: begin
        if (take) begin
          len_nxt   = rx_data;
          state_nxt = frgch_pkg::ST_CNT;
        end
      end
      frgch_pkg::ST_CNT: begin
        if (take) begin
          cnt_nxt = rx_data;
          idx_nxt = 8'h00;
          if (len_r != (8'h01 + {rx_data[6:0], 1'b0}) || rx_data > MAX_CNT) begin
            state_nxt = frgch_pkg::ST_SYNC0;
          end else begin
            state_nxt = (rx_data == 8'h00) ? frgch_pkg::ST_CRC_H : frgch_pkg::ST_ID_H;
          end
        end
      end
      frgch_pkg::ST_ID_H: begin
        if (take) begin
          hi_nxt    = rx_data;
          state_nxt = frgch_pkg::ST_ID_L;
        end
      end
      frgch_pkg::ST_ID_L: begin
        if (take) begin
          idx_nxt   = idx_r + 8'h01;
          state_nxt = last_idx ? frgch_pkg::ST_CRC_H : frgch_pkg::ST_ID_H;
        end
      end
      frgch_pkg::ST_CRC_H: begin
        if (take) begin
          hi_nxt    = rx_data;
          state_nxt = frgch_pkg::ST_CRC_L;
        end
      end
      frgch_pkg::ST_CRC_L: begin
        if (take) begin
          idx_nxt    = 8'h00;
          step_nxt   = frgch_pkg::STEP_ID;
          ok_cnt_nxt = 8'h00;
          fail_nxt   = 1'b0;
          if ({hi_r, rx_data} == rx_crc_r && cnt_r != 8'h00) begin
            state_nxt = frgch_pkg::ST_SCAN;
          end else begin
            state_nxt = frgch_pkg::ST_SYNC0;
          end
        end
      end
      frgch_pkg::ST_SCAN: begin
        // first pass counts successes so the length byte is known up front
        if (step_r == frgch_pkg::STEP_ID) begin
          step_nxt = frgch_pkg::STEP_VAL;
        end else if (step_r == frgch_pkg::STEP_VAL) begin
          id_nxt   = id_q;
          step_nxt = frgch_pkg::STEP_USE;
        end else begin
          ok_cnt_nxt = ok_cnt_r + {7'h00, ok_now};
          fail_nxt   = fail_r | ~ok_now;
          step_nxt   = frgch_pkg::STEP_ID;
          idx_nxt    = idx_r + 8'h01;
          if (last_idx) begin
            idx_nxt    = 8'h00;
            bsel_nxt   = 3'h0;
            tx_crc_nxt = frgch_pkg::CRC_INIT;
            if (ok_cnt_nxt != 8'h00) begin
              state_nxt = frgch_pkg::ST_HDR;
            end else begin
              state_nxt = frgch_pkg::ST_ERR;
            end
          end
        end
      end
      frgch_pkg::ST_HDR: begin
        if (push) begin
          bsel_nxt = bsel_r + 3'h1;
          if (bsel_r == frgch_pkg::HDR_LAST_RESP) begin
            bsel_nxt  = 3'h0;
            step_nxt  = frgch_pkg::STEP_ID;
            state_nxt = frgch_pkg::ST_FIELD;
          end
        end
      end
      frgch_pkg::ST_FIELD: begin
        // second pass emits id and value of each good field in payload order
        if (step_r == frgch_pkg::STEP_ID) begin
          step_nxt = frgch_pkg::STEP_VAL;
        end else if (step_r == frgch_pkg::STEP_VAL) begin
          id_nxt   = id_q;
          step_nxt = frgch_pkg::STEP_USE;
        end else if (!ok_now || (push && bsel_r == 3'h3)) begin
          bsel_nxt = 3'h0;
          step_nxt = frgch_pkg::STEP_ID;
          idx_nxt  = idx_r + 8'h01;
          if (last_idx) begin
            state_nxt = frgch_pkg::ST_TAIL;
          end
        end else if (push) begin
          bsel_nxt = bsel_r + 3'h1;
        end
      end
      frgch_pkg::ST_TAIL: begin
        if (push) begin
          bsel_nxt = bsel_r + 3'h1;
          if (bsel_r[0]) begin
            bsel_nxt   = 3'h0;
            tx_crc_nxt = frgch_pkg::CRC_INIT;
            if (fail_r && !err_r) begin
              state_nxt = frgch_pkg::ST_ERR;
            end else begin
              state_nxt = frgch_pkg::ST_SYNC0;
            end
          end
        end
      end
      frgch_pkg::ST_ERR: begin
        if (push) begin
          bsel_nxt = bsel_r + 3'h1;
          if (bsel_r == frgch_pkg::HDR_LAST_ERR) begin
            bsel_nxt  = 3'h0;
            err_nxt   = 1'b1;
            state_nxt = frgch_pkg::ST_TAIL;
          end
        end
      end
      default: begin
        state_nxt = frgch_pkg::ST_SYNC0;
      end
    endcase
    // bytes are taken only while hunting or parsing, never while scanning or answering
    rx_ready_nxt = state_nxt inside {frgch_pkg::ST_SYNC0, frgch_pkg::ST_SYNC1, frgch_pkg::ST_TYPE_H,
                                     frgch_pkg::ST_TYPE_L, frgch_pkg::ST_LEN, frgch_pkg::ST_CNT,
                                     frgch_pkg::ST_ID_H, frgch_pkg::ST_ID_L, frgch_pkg::ST_CRC_H,
                                     frgch_pkg::ST_CRC_L};
  end

  // state registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r  <= frgch_pkg::ST_SYNC0;
      idx_r    <= frgch_pkg::BYTE_RST;
      cnt_r    <= frgch_pkg::BYTE_RST;
      len_r    <= frgch_pkg::BYTE_RST;
      hi_r     <= frgch_pkg::BYTE_RST;
      typ_r    <= frgch_pkg::WORD_RST;
      rx_crc_r <= frgch_pkg::CRC_INIT;
      tx_crc_r <= frgch_pkg::CRC_INIT;
      ok_cnt_r <= frgch_pkg::BYTE_RST;
      fail_r   <= 1'b0;
      err_r    <= 1'b0;
      live_r   <= 1'b0;
      step_r   <= frgch_pkg::STEP_ID;
      bsel_r   <= 3'h0;
      id_r     <= frgch_pkg::WORD_RST;
      rx_ready <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      idx_r    <= idx_nxt;
      cnt_r    <= cnt_nxt;
      len_r    <= len_nxt;
      hi_r     <= hi_nxt;
      typ_r    <= typ_nxt;
      rx_crc_r <= rx_crc_nxt;
      tx_crc_r <= tx_crc_nxt;
      ok_cnt_r <= ok_cnt_nxt;
      fail_r   <= fail_nxt;
      err_r    <= err_nxt;
      live_r   <= live_nxt;
      step_r   <= step_nxt;
      bsel_r   <= bsel_nxt;
      id_r     <= id_nxt;
      rx_ready <= rx_ready_nxt;
    end
  end
endmodule

// file: tb/frgch_top_checker.sv
// port-level assertions for the field read/get handler: reset, stall hold, answer timing
// assumes it is bound to every frgch_top instance and sees only that module's ports
`timescale 1ns/10ps
module frgch_top_checker #(
  parameter int MAX_FIELDS = 16
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        upd_en,
  input wire logic        upd_live,
  input wire logic [15:0] upd_id,
  input wire logic [15:0] upd_value
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // bounds: a full scan plus header, and a fully stalled sixteen-field answer
  localparam int ANS_MAX  = 200;
  localparam int BUSY_MAX = 1000;

  // reset forces both streams idle
  a_reset_tx_idle: assert property (disable iff (1'b0) rst |=> !tx_valid)
    else $error("tx_valid high after a reset edge");
  a_reset_rx_idle: assert property (disable iff (1'b0) rst |=> !rx_ready)
    else $error("rx_ready high after a reset edge");
  a_reset_tx_zero: assert property (disable iff (1'b0) rst |=> tx_data == 8'h00)
    else $error("tx_data not cleared by reset");
  a_release_rx_up: assert property ($fell(rst) |-> !rx_ready ##[1:2] rx_ready)
    else $error("rx_ready late after reset release");

  // a stalled response byte never moves or vanishes
  a_stall_holds_byte: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("response byte changed while stalled");

  // a good command always gets an answer, led by the sync byte
  a_answer_due: assert property ($fell(rx_ready) |-> ##[1:ANS_MAX] tx_valid)
    else $error("no answer after a command");
  a_sync_first: assert property ($fell(rx_ready) && !tx_valid |->
    first_match(##[1:ANS_MAX] tx_valid) ##0 (tx_data == frgch_pkg::SYNC_BYTE))
    else $error("answer does not start with sync");
  a_busy_ends: assert property ($fell(rx_ready) |-> ##[1:BUSY_MAX] rx_ready)
    else $error("command side never reopened");
endmodule

bind frgch_top frgch_top_checker #(.MAX_FIELDS(MAX_FIELDS)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .upd_en(upd_en), .upd_live(upd_live), .upd_id(upd_id), .upd_value(upd_value));

// file: tb/frgch_host_model.sv
// host model: sends queued command bytes and collects response bytes
// assumes the bench fills sendq and reads got; slow makes long output stalls
`timescale 1ns/10ps
module frgch_host_model (
  input  wire logic       ref_clk,
  input  wire logic       rx_ready,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  logic [7:0] sendq [$];
  logic [7:0] got [$];
  logic       slow = 1'b0;
  int         tick = 0;
  logic       tx_take = 1'b0;
  logic       rx_take = 1'b0;
  logic [7:0] tx_seen = 8'h00;

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b1;
  end

  // note mid-cycle what the coming edge accepts, clear of the edge's own flop updates
  always @(negedge ref_clk) begin
    tx_take = (tx_valid === 1'b1) && tx_ready;
    rx_take = rx_valid && (rx_ready === 1'b1);
    tx_seen = tx_data;
  end

  // take answers, retire an accepted byte, then drive just after the edge
  always @(posedge ref_clk) begin
    if (tx_take) got.push_back(tx_seen);
    if (rx_take) void'(sendq.pop_front());
    tick = tick + 1;
    #1;
    tx_ready = !slow || (tick % 8 == 0);
    if (sendq.size() > 0) begin
      rx_valid = 1'b1;
      rx_data  = sendq[0];
    end else begin
      rx_valid = 1'b0;
      rx_data  = ~rx_data;  // idle line keeps changing
    end
  end
endmodule

// file: tb/frgch_top_tb.sv
// self-checking bench for the field read/get handler
// assumes the host model carries commands in and answers out
`timescale 1ns/10ps
module frgch_top_tb;
  logic        ref_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic        upd_en    = 1'b0;
  logic        upd_live  = 1'b0;
  logic [15:0] upd_id    = 16'h0000;
  logic [15:0] upd_value = 16'h0000;
  logic        rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0]  rx_data, tx_data;
  logic [15:0] stv [256];
  logic [15:0] lvv [256];
  int          errors    = 0;
  int          tests_run = 0;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  frgch_top #(.MAX_FIELDS(16)) dut (
    .ref_clk(ref_clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .upd_en(upd_en), .upd_live(upd_live), .upd_id(upd_id), .upd_value(upd_value));
  frgch_host_model host (
    .ref_clk(ref_clk), .rx_ready(rx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

  // verdict and end of run
  task automatic finish_test;
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // bench's own crc-16 step, msb first
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ frgch_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // append sync, type, body and crc to a byte queue
  task automatic frame(ref logic [7:0] q [$], input logic [15:0] t, input logic [7:0] b [$]);
    logic [15:0] c;
    c = frgch_pkg::CRC_INIT;
    b.push_front(t[7:0]);
    b.push_front(t[15:8]);
    foreach (b[i]) c = crc(c, b[i]);
    q = {q, 8'h55, 8'h55, b, c[15:8], c[7:0]};
  endtask

  // write one field of one bank and remember it
  task automatic load(input logic live, input logic [15:0] id, input logic [15:0] v);
    @(posedge ref_clk);
    #1;
    upd_en    = 1'b1;
    upd_live  = live;
    upd_id    = id;
    upd_value = v;
    if (live) lvv[id[7:0]] = v;
    else stv[id[7:0]] = v;
    @(posedge ref_clk);
    #1;
    upd_en = 1'b0;
  endtask

  // send one command (length or crc may be spoiled) and compare the answer
  task automatic exchange(input logic [15:0] t, input logic [15:0] ids [$],
                          input logic [7:0] dl, input logic [7:0] dc);
    logic [7:0]  c [$];
    logic [7:0]  e [$];
    logic [7:0]  b [$];
    logic [7:0]  r [$];
    logic [15:0] v;
    logic        live;
    int          bad;
    live = (t == frgch_pkg::TYPE_LIVE_GET);
    bad  = 0;
    b = '{8'(1 + 2 * ids.size()) + dl, 8'(ids.size())};
    foreach (ids[i]) begin
      b = {b, ids[i][15:8], ids[i][7:0]};
      v = live ? lvv[ids[i][7:0]] : stv[ids[i][7:0]];
      if (ids[i] < 16'h0100 && (live || ids[i] < 16'h00C0)) begin
        r = {r, ids[i][15:8], ids[i][7:0], v[15:8], v[7:0]};
      end else begin
        bad++;
      end
    end
    frame(c, t, b);
    c[c.size() - 1] ^= dc;
    if (dl == 8'h00 && dc == 8'h00 && r.size() > 0) begin
      b = {8'(1 + r.size()), 8'(r.size() / 4), r};
      frame(e, t, b);
    end
    if (dl == 8'h00 && dc == 8'h00 && bad > 0) begin
      b = '{frgch_pkg::ERR_LEN, t[15:8], t[7:0]};
      frame(e, frgch_pkg::TYPE_ERROR, b);
    end
    @(posedge ref_clk);
    #2;
    host.sendq = c;
    for (int i = 0; i < 4000 && host.got.size() < e.size(); i++) @(posedge ref_clk);
    repeat (150) @(posedge ref_clk);
    #2;
    tests_run++;
    if (host.got.size() != e.size()) begin
      errors++;
      $display("[FAIL] answer length exp %0d got %0d", e.size(), host.got.size());
    end else begin
      foreach (e[i]) begin
        tests_run++;
        if (host.got[i] !== e[i]) begin
          errors++;
          $display("[FAIL] answer byte %0d exp %h got %h", i, e[i], host.got[i]);
        end
      end
    end
    host.got.delete();
  endtask

  // two stored fields under long stalls, buffer fills and drains
  task automatic t_stored;
    host.slow = 1'b1;
    exchange(frgch_pkg::TYPE_STORED_READ, '{16'h0001, 16'h00BF}, 8'h00, 8'h00);
    host.slow = 1'b0;
  endtask

  // live get: algorithm id, out-of-range id, repeated id
  task automatic t_live_mix;
    exchange(frgch_pkg::TYPE_LIVE_GET, '{16'h00C0, 16'h0100, 16'h0001, 16'h0001},
             8'h00, 8'h00);
  endtask

  // stored read of failing ids only gives the error packet alone
  task automatic t_stored_fail;
    exchange(frgch_pkg::TYPE_STORED_READ, '{16'h00C0, 16'hFFFF}, 8'h00, 8'h00);
  endtask

  // spoiled length and crc are dropped, the next good command still answered
  task automatic t_drop;
    exchange(frgch_pkg::TYPE_LIVE_GET, '{16'h0004}, 8'h01, 8'h00);
    exchange(frgch_pkg::TYPE_LIVE_GET, '{16'h0004}, 8'h00, 8'h01);
    exchange(frgch_pkg::TYPE_STORED_READ, '{16'h0004}, 8'h00, 8'h00);
  endtask

  // sixteen stored ids straddling the algorithm range, stalled consumer
  task automatic t_full;
    logic [15:0] ids [$];
    for (int i = 0; i < 16; i++) ids.push_back(16'h00B8 + 16'(i));
    host.slow = 1'b1;
    exchange(frgch_pkg::TYPE_STORED_READ, ids, 8'h00, 8'h00);
    host.slow = 1'b0;
  endtask

  // main sequence: reset, fill both banks with distinct values, run scenarios
  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 512; i++) load(i[8], 16'(i[7:0]), {i[8] ? 8'hC3 : 8'h5A, i[7:0]});
    t_stored();
    t_live_mix();
    t_stored_fail();
    t_drop();
    t_full();
    finish_test();
  end

  // watchdog
  initial begin
    #600000;
    errors++;
    finish_test();
  end
endmodule
